// ==== src/fwp_map.vh ====
// Command codes and timing constants for the flash writer-mode programmer.
`ifndef FWP_MAP_VH
`define FWP_MAP_VH
`define FWP_CMD_READ 8'h00
`define FWP_CMD_ERASE 8'h20
`define FWP_CMD_ERASE_VFY 8'hA0
`define FWP_CMD_AUTO_ERASE 8'h30
`define FWP_CMD_PROGRAM 8'h40
`define FWP_CMD_PROG_VFY 8'hC0
`define FWP_CMD_RESET 8'hFF
`define FWP_ERASED_BYTE 8'hFF
`define FWP_CLK_NS 5
// Strobe low and high widths (ns), least: from the write pulse width and the command write cycle.
`define FWP_T_WEP_NS 70
`define FWP_T_WEH_NS 60
`define FWP_CYC_WEP ((`FWP_T_WEP_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
`define FWP_CYC_WEH ((`FWP_T_WEH_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
// Supply setup and hold around the supply step (ns), least.
`define FWP_T_VPS_NS 100
`define FWP_CYC_VPS ((`FWP_T_VPS_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
// Verify access time (ns), longest; data sampled once it has elapsed.
`define FWP_T_VA_NS 500
`define FWP_CYC_VA ((`FWP_T_VA_NS + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
// Output enable setup before verify (us), least.
`define FWP_T_OERS_US 6
`define FWP_CYC_OERS ((`FWP_T_OERS_US * 1000 + `FWP_CLK_NS - 1) / `FWP_CLK_NS)
// Erase interval 9 ms to 11 ms; the midpoint is used.
`define FWP_T_ET_MIN_US 9000
`define FWP_T_ET_MAX_US 11000
`define FWP_CYC_ET (((`FWP_T_ET_MIN_US + `FWP_T_ET_MAX_US) / 2) * 1000 / `FWP_CLK_NS)
// Auto-erase longest total time (s).
`define FWP_T_AET_MAX_S 30
// Thirty seconds of 5 ns cycles, kept inside the 34-bit wait counter.
`define FWP_CYC_AET (34'd6 * 34'd1000000000)
`endif

// ==== src/fwp_ctrl.v ====
// Host-side controller driving a flash array in writer mode through its parallel pins.
`timescale 1ns/10ps
`include "fwp_map.vh"
// Operation
// - Command writes only at programming supply level.
// - Array-read states keep supply at logic level; verify reads run at programming level.
// - Command 00 returns to array read.
// - Erase is two writes of 20.
// - Auto-erase is two writes of 30.
// - Program: write 40, then address and data.
// - Program-verify: write C0, then read.
// - Reset is two writes of FF.
// - Erase interval between 9 and 11 ms.
// - Strobes high while supply level changes.
module fwp_ctrl #(
  parameter [23:0] OERS_CYC = `FWP_CYC_OERS,
  parameter [23:0] ET_CYC = `FWP_CYC_ET,
  parameter [33:0] AET_CYC = `FWP_CYC_AET
) (
  input wire clk, // 200 MHz clock
  input wire rstn, // Asynchronous reset, active low
  input wire cmd_valid, // Request present
  output wire cmd_ready, // Controller idle, request taken
  input wire [2:0] cmd_op, // 0 read,1 erase,2 erase-verify,3 auto-erase,4 program,5 program-verify,6 reset
  input wire [16:0] cmd_addr, // Target address
  input wire [7:0] cmd_data, // Program byte
  output reg [7:0] rsp_data_q, // Byte read back
  output reg rsp_valid_q, // One-cycle pulse: operation done
  output reg rsp_blank_q, // Read byte equals erased value
  output reg program_supply_high_q, // High: program_supply_pin at programming level
  output reg ce_n_q, // Chip select, active low
  output reg oe_n_q, // Output enable, active low
  output reg we_n_q, // Write strobe, active low
  output reg [16:0] address_bus_q, // Address pins
  output reg [7:0] data_bus_o_q, // Data pins driven
  output reg data_bus_oe_q, // High while driving data pins
  input wire [7:0] data_bus_i // Data pins sampled
);

  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  reg [7:0] din1_q;
  reg [7:0] din2_q;
  reg [7:0] din3_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      din1_q <= 8'h00;
      din2_q <= 8'h00;
      din3_q <= 8'h00;
    end else begin
      din1_q <= data_bus_i;
      din2_q <= din1_q;
      din3_q <= din2_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  localparam [9:0] S_IDLE = 10'b00_0000_0001;
  localparam [9:0] S_VUP = 10'b00_0000_0010;
  localparam [9:0] S_WLO = 10'b00_0000_0100;
  localparam [9:0] S_WHI = 10'b00_0000_1000;
  localparam [9:0] S_WAIT = 10'b00_0001_0000;
  localparam [9:0] S_VDN = 10'b00_0010_0000;
  localparam [9:0] S_RLO = 10'b00_0100_0000;
  localparam [9:0] S_RSMP = 10'b00_1000_0000;
  localparam [9:0] S_DONE = 10'b01_0000_0000;
  localparam [9:0] S_VRD = 10'b10_0000_0000;

  localparam [2:0] OP_READ = 3'h0;
  localparam [2:0] OP_ERASE = 3'h1;
  localparam [2:0] OP_EVFY = 3'h2;
  localparam [2:0] OP_AUTO = 3'h3;
  localparam [2:0] OP_PROG = 3'h4;
  localparam [2:0] OP_PVFY = 3'h5;

  reg [9:0] state_q;
  reg [2:0] op_q;
  reg [16:0] addr_q;
  reg [7:0] data_q;
  reg cyc_q;
  reg [33:0] cnt_q;
  reg [7:0] last_q;

  // Ready stays low until the internal reset is released, so no request is lost.
  assign cmd_ready = state_q[0] & rst_n;

  // First and second write cycle of each command; read, erase-verify and program-verify have only the first.
  reg [7:0] wr_byte;
  reg [16:0] wr_addr;
  reg two_writes;
  always @* begin
    wr_addr = 17'h0_0000;
    two_writes = 1'b1;
    case (op_q)
      OP_READ: begin
        wr_byte = `FWP_CMD_READ;
        two_writes = 1'b0;
      end
      OP_ERASE: wr_byte = `FWP_CMD_ERASE;
      OP_EVFY: begin
        wr_byte = `FWP_CMD_ERASE_VFY;
        wr_addr = addr_q;
        two_writes = 1'b0;
      end
      OP_AUTO: wr_byte = `FWP_CMD_AUTO_ERASE;
      OP_PROG: wr_byte = `FWP_CMD_PROGRAM;
      OP_PVFY: begin
        wr_byte = `FWP_CMD_PROG_VFY;
        two_writes = 1'b0;
      end
      default: wr_byte = `FWP_CMD_RESET;
    endcase
    if (cyc_q && op_q == OP_PROG) begin
      wr_byte = data_q;
      wr_addr = addr_q;
    end
  end

  wire cnt_zero = (cnt_q == 34'h0_0000_0000);
  wire is_verify = (op_q == OP_EVFY) || (op_q == OP_PVFY);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      op_q <= 3'h0;
      addr_q <= 17'h0_0000;
      data_q <= 8'h00;
      cyc_q <= 1'b0;
      cnt_q <= 34'h0_0000_0000;
      last_q <= 8'h00;
      rsp_data_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_blank_q <= 1'b0;
      program_supply_high_q <= 1'b0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      address_bus_q <= 17'h0_0000;
      data_bus_o_q <= 8'h00;
      data_bus_oe_q <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      last_q <= din3_q;
      if (!cnt_zero) begin
        cnt_q <= cnt_q - 34'h0_0000_0001;
      end
      case (state_q)
        S_IDLE: begin
          if (cmd_valid) begin
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            data_q <= cmd_data;
            cyc_q <= 1'b0;
            // Strobes are all high here, so the supply may step.
            program_supply_high_q <= 1'b1;
            cnt_q <= `FWP_CYC_VPS;
            state_q <= S_VUP;
          end
        end
        S_VUP: begin
          if (cnt_zero) begin
            ce_n_q <= 1'b0;
            we_n_q <= 1'b0;
            address_bus_q <= wr_addr;
            data_bus_o_q <= wr_byte;
            data_bus_oe_q <= 1'b1;
            cnt_q <= `FWP_CYC_WEP;
            state_q <= S_WLO;
          end
        end
        S_WLO: begin
          if (cnt_zero) begin
            we_n_q <= 1'b1;
            cnt_q <= `FWP_CYC_WEH;
            state_q <= S_WHI;
          end
        end
        S_WHI: begin
          if (cnt_zero) begin
            data_bus_oe_q <= 1'b0;
            ce_n_q <= 1'b1;
            if (two_writes && !cyc_q) begin
              cyc_q <= 1'b1;
              cnt_q <= 34'h0_0000_0001;
              state_q <= S_VUP;
            end else begin
              // Device has no identification mode, so nothing is probed.
              if (op_q == OP_ERASE) cnt_q <= {10'h000, ET_CYC};
              else if (op_q == OP_AUTO) cnt_q <= AET_CYC;
              else if (is_verify) cnt_q <= {10'h000, OERS_CYC};
              else cnt_q <= 34'h0_0000_0001;
              state_q <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          if (cnt_zero) begin
            if (is_verify && !cyc_q) begin
              ce_n_q <= 1'b0;
              oe_n_q <= 1'b0;
              cnt_q <= `FWP_CYC_VA + 34'h0_0000_0004;
              state_q <= S_VRD;
            end else begin
              cnt_q <= `FWP_CYC_VPS;
              program_supply_high_q <= 1'b0;
              state_q <= S_VDN;
            end
          end
        end
        S_VRD: begin
          if (cnt_zero) begin
            rsp_data_q <= last_q;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            // Strobes settle high for two cycles before the supply steps down.
            cyc_q <= 1'b1;
            cnt_q <= 34'h0_0000_0001;
            state_q <= S_WAIT;
          end
        end
        S_VDN: begin
          if (cnt_zero) begin
            if (op_q == OP_READ) begin
              ce_n_q <= 1'b0;
              oe_n_q <= 1'b0;
              address_bus_q <= addr_q;
              cnt_q <= `FWP_CYC_VA + 34'h0_0000_0004;
              state_q <= S_RLO;
            end else begin
              state_q <= S_DONE;
            end
          end
        end
        S_RLO: begin
          if (cnt_zero) begin
            state_q <= S_RSMP;
          end
        end
        S_RSMP: begin
          rsp_data_q <= last_q;
          ce_n_q <= 1'b1;
          oe_n_q <= 1'b1;
          state_q <= S_DONE;
        end
        S_DONE: begin
          rsp_valid_q <= 1'b1;
          rsp_blank_q <= (rsp_data_q == `FWP_ERASED_BYTE);
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule // fwp_ctrl

// ==== bench/fwp_ctrl_monitor.sv ====
// Pin sequencing checker for the writer-mode controller.
`timescale 1ns/10ps
module fwp_ctrl_monitor (
  input logic clk, // clock
  input logic rstn, // reset
  input logic cmd_valid, // request
  input logic cmd_ready, // idle
  input logic [7:0] rsp_data_q, // byte
  input logic rsp_valid_q, // done
  input logic rsp_blank_q, // erased
  input logic program_supply_high_q, // supply
  input logic ce_n_q, // select
  input logic oe_n_q, // out enable
  input logic we_n_q, // strobe
  input logic data_bus_oe_q // driving
);
  // ----
  // Properties
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_wr; !we_n_q |-> program_supply_high_q && !ce_n_q && oe_n_q; endproperty
  a_wr: assert property (p_wr) else $error("strobe outside write state");
  property p_drv; data_bus_oe_q |-> oe_n_q && !ce_n_q; endproperty
  a_drv: assert property (p_drv) else $error("bus driven against output");
  property p_sup; $changed(program_supply_high_q) |-> ce_n_q && oe_n_q && we_n_q && $past(ce_n_q && oe_n_q); endproperty
  a_sup: assert property (p_sup) else $error("supply moved with strobes low");
  property p_rise; $rose(program_supply_high_q) |-> ce_n_q [*8]; endproperty
  a_rise: assert property (p_rise) else $error("select too soon after supply");
  property p_pulse; rsp_valid_q |=> !rsp_valid_q; endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse too long");
  property p_blank; rsp_valid_q |-> rsp_blank_q == (rsp_data_q == 8'hFF); endproperty
  a_blank: assert property (p_blank) else $error("blank flag wrong");
  property p_rd; $fell(oe_n_q) |-> we_n_q && !ce_n_q ##1 !oe_n_q [*8]; endproperty
  a_rd: assert property (p_rd) else $error("read cycle cut short");
  property p_idle; cmd_ready |-> ce_n_q && we_n_q && oe_n_q && !data_bus_oe_q; endproperty
  a_idle: assert property (p_idle) else $error("strobes active while idle");
  property p_take; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
  a_take: assert property (p_take) else $error("ready after take");
endmodule // fwp_ctrl_monitor
bind fwp_ctrl fwp_ctrl_monitor u_mon (.*);

// ==== bench/fwp_dev.sv ====
// Behavioural flash array answering the writer-mode pins.
`timescale 1ns/10ps
module fwp_dev #(parameter LAT = 400) (
  input logic ce_n, // select
  input logic oe_n, // out enable
  input logic we_n, // strobe
  input logic vpp, // supply high
  input logic [16:0] a, // address
  input logic [7:0] din, // bus in
  output logic [7:0] dq // bus out
);
  // No identification mode is offered.
  logic [7:0] mem [int];
  logic [2:0] st = 0;
  logic [16:0] va = 0;
  logic [7:0] val, lastv = 0;
  logic en;
  function automatic [7:0] rdm(input [16:0] x);
    return mem.exists(x) ? mem[x] : 8'hFF;
  endfunction
  always @(posedge we_n) if (!ce_n && oe_n && vpp) begin
    case (st)
      1: begin if (din == 8'h20) mem.delete(); st = 0; end
      3: begin if (din == 8'h30) mem.delete(); st = 0; end
      4: begin mem[a] = din; va = a; st = 0; end
      6: st = 0;
      default: case (din)
        8'h20: st = 1;
        8'hA0: begin st = 2; va = a; end
        8'h30: st = 3;
        8'h40: st = 4;
        8'hC0: st = 5;
        8'hFF: st = 6;
        default: st = 0;
      endcase
    endcase
  end
  always @(ce_n, oe_n, we_n, a, st, va) begin
    en = !ce_n && !oe_n && we_n;
    val = rdm(st == 0 ? a : va);
  end
  // Released bus shows the inverse of the last byte, so stale data never passes.
  always @(posedge oe_n) lastv <= dq;
  assign #LAT dq = en ? val : ~lastv;
endmodule // fwp_dev

// ==== bench/fwp_ctrl_tb.sv ====
// Self-checking bench for the writer-mode controller.
`timescale 1ns/10ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module fwp_ctrl_tb;
  logic clk = 0, rstn = 0, cmd_valid = 0, cmd_ready, rsp_valid_q, rsp_blank_q, sup, ce_n, oe_n, we_n, doe;
  logic [2:0] cmd_op = 0;
  logic [16:0] cmd_addr = 0, ab;
  logic [7:0] cmd_data = 0, rsp, dbo, dq, d;
  logic [7:0] refm [int];
  logic [31:0] seed = 25;
  int errors = 0, num_checks = 0;
  wire [7:0] dbi = doe ? dbo : dq;
  always #2.5 clk = ~clk;
  fwp_ctrl #(.OERS_CYC(10), .ET_CYC(50), .AET_CYC(100)) dut (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_data_q(rsp),
    .rsp_valid_q(rsp_valid_q), .rsp_blank_q(rsp_blank_q), .program_supply_high_q(sup), .ce_n_q(ce_n),
    .oe_n_q(oe_n), .we_n_q(we_n), .address_bus_q(ab), .data_bus_o_q(dbo), .data_bus_oe_q(doe), .data_bus_i(dbi));
  fwp_dev u_dev (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .vpp(sup), .a(ab), .din(dbi), .dq(dq));
  function automatic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic [7:0] expd(input [16:0] x);
    return refm.exists(x) ? refm[x] : 8'hFF;
  endfunction
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic op(input [2:0] o, input [16:0] a, input [7:0] dd);
    int n;
    n = 0;
    @(negedge clk);
    while (!cmd_ready && n < 4000) begin @(negedge clk); n++; end
    @(posedge clk);
    cmd_valid <= 1;
    cmd_op <= o;
    cmd_addr <= a;
    cmd_data <= dd;
    @(posedge clk);
    cmd_valid <= 0;
    @(negedge clk);
    while (!rsp_valid_q && n < 4000) begin @(negedge clk); n++; end
    if (n >= 4000) begin errors++; finish_test(); end
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    logic [16:0] a;
    repeat (5) @(posedge clk);
    rstn <= 1;
    a = rnd();
    op(0, a, 0);
    `CHK("blank", 8'hFF, rsp)
    for (int i = 0; i < 5; i++) begin
      a = (i == 0) ? 17'h0_0000 : (i == 1) ? 17'h1_FFFF : rnd();
      d = (i == 0) ? 8'h00 : rnd();
      op(4, a, d);
      refm[a] = d;
      op(5, a, 0);
      `CHK("pvfy", d, rsp)
      op(0, a, 0);
      `CHK("read", expd(a), rsp)
      $display("test %0d done", i);
    end
    op(6, 0, 0);
    op(0, a, 0);
    `CHK("after reset", expd(a), rsp)
    op(1, 0, 0);
    refm.delete();
    op(2, a, 0);
    `CHK("evfy", 8'hFF, rsp)
    op(4, a, 8'h5A);
    op(3, 0, 0);
    op(0, a, 0);
    `CHK("auto", 8'hFF, rsp)
    $display("test erase done");
    finish_test();
  end
endmodule // fwp_ctrl_tb
